/* logic/tfvr_timer.sv */
// Timer slice: count, reload, compare and flag registers behind an APB slave.
// Assumes clk at 10 MHz, synchronous active-high reset, capture pin asynchronous.
`timescale 1ns/1ps
`default_nettype none
module tfvr_timer #(
  parameter bit HAS_ALT = 1'b1
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tfvr_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic      [31:0]                 prdata,
  // Capture pin and alternate pin
  input  wire logic                        capture_pin,
  output logic                             alt_pin_out,
  output logic                             alt_pin_oe,
  // Interrupt request
  output logic                             irq
);

  tfvr_pkg::tfvr_state_t st;
  tfvr_pkg::tfvr_state_t next_st;

  // All checks below sample on clk and rest during reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  logic                        cap_lvl;
  logic [tfvr_pkg::IDX_W-1:0]  idx;
  logic                        access;
  logic                        wr;
  logic                        hit;
  logic                        cap_evt;
  logic [15:0]                 cnt_nx;
  logic                        ovf16;
  logic                        ovf_h;
  logic                        ovf_l;
  logic                        m16;
  logic                        mh;
  logic                        ml;
  logic                        src_evt;
  logic [31:0]                 rd_val;

  // Capture pin is asynchronous, so it is synchronised first
  tfvr_sync u_cap_sync (
    .clk   (clk),
    .reset (reset),
    .d     (capture_pin),
    .q     (cap_lvl)
  );

  // Bus decode: the write lands on the edge where pready is seen high
  assign idx    = paddr[tfvr_pkg::ADDR_W-1:2];
  assign access = psel && penable;
  assign wr     = access && pwrite && st.pready;

  // Address decode and read mux, sampled from current state
  always_comb
  begin
    hit    = (paddr[1:0] == 2'b00);
    rd_val = '0;
    unique case (idx)
      tfvr_pkg::IDX_CONFIG:
        rd_val = 32'({st.wmode, st.main_ien, 2'b00, st.run_low, st.run,
                      2'b00, st.cap_en});
      tfvr_pkg::IDX_CTRL_B:
        rd_val = 32'({st.low_ien, st.alt_oe, st.alt_pol, 1'b0,
                      st.tf, st.tfl, st.tcc, st.tcl});
      tfvr_pkg::IDX_CNT:
        rd_val = 32'({st.wmode ? tfvr_pkg::ZERO8 : st.cnt[15:8],
                      st.cnt[7:0]});
      tfvr_pkg::IDX_CNT_HI:
        rd_val = 32'(st.cnt[15:8]);
      tfvr_pkg::IDX_RLD:
        rd_val = 32'({st.wmode ? tfvr_pkg::ZERO8 : st.rld[15:8],
                      st.rld[7:0]});
      tfvr_pkg::IDX_RLD_HI:
        rd_val = 32'(st.rld[15:8]);
      tfvr_pkg::IDX_CMP:
        rd_val = 32'({st.wmode ? tfvr_pkg::ZERO8 : st.cmp[15:8],
                      st.cmp[7:0]});
      tfvr_pkg::IDX_CMP_HI:
        rd_val = 32'(st.cmp[15:8]);
      default:
        hit = 1'b0;
    endcase
  end

  // Counting, matching, flags, pin and bus response in one next-state block
  always_comb
  begin
    next_st = st;
    cnt_nx  = st.cnt;
    ovf16   = 1'b0;
    ovf_h   = 1'b0;
    ovf_l   = 1'b0;
    cap_evt = st.cap_en && cap_lvl && !st.cap_prev;
    next_st.cap_prev = cap_lvl;

    // Counter advance; width mode picks one 16-bit or two 8-bit timers
    if (!st.wmode)
    begin
      if (st.run)
      begin
        if (st.cnt == tfvr_pkg::FULL16)
        begin
          cnt_nx = st.rld;
          ovf16  = 1'b1;
        end
        else
          cnt_nx = st.cnt + 16'h0001;
      end
    end
    else
    begin
      if (st.run)
      begin
        if (st.cnt[15:8] == tfvr_pkg::FULL8)
        begin
          cnt_nx[15:8] = st.rld[15:8];
          ovf_h        = 1'b1;
        end
        else
          cnt_nx[15:8] = st.cnt[15:8] + 8'h01;
      end
      if (st.run_low)
      begin
        if (st.cnt[7:0] == tfvr_pkg::FULL8)
        begin
          cnt_nx[7:0] = st.rld[7:0];
          ovf_l       = 1'b1;
        end
        else
          cnt_nx[7:0] = st.cnt[7:0] + 8'h01;
      end
    end
    next_st.cnt = cnt_nx;

    // Matches only on an advance, so a parked counter does not re-flag
    m16 = !st.wmode && st.run && !st.cap_en && (cnt_nx == st.cmp);
    mh  = st.wmode && st.run && !st.cap_en
          && (cnt_nx[15:8] == st.cmp[15:8]);
    ml  = st.wmode && st.run_low && (cnt_nx[7:0] == st.cmp[7:0]);

    // Capture touches the full timer, or only the high byte in dual mode
    if (cap_evt)
    begin
      if (st.wmode)
        next_st.cmp[15:8] = st.cnt[15:8];
      else
        next_st.cmp = st.cnt;
    end

    // Hardware flag sets
    next_st.tf  = st.tf  || ovf16 || ovf_h;
    next_st.tfl = st.tfl || ovf_l;
    next_st.tcc = st.tcc || m16 || mh || cap_evt;
    next_st.tcl = st.tcl || ml;

    // Register writes; low bytes always pass, upper bytes via word registers only in 16-bit
    if (wr && hit)
    begin
      unique case (idx)
        tfvr_pkg::IDX_CONFIG:
        begin
          next_st.wmode    = pwdata[tfvr_pkg::WMODE_BIT];
          next_st.main_ien = pwdata[tfvr_pkg::MAIN_IEN_BIT];
          next_st.run_low  = pwdata[tfvr_pkg::RUN_LOW_BIT];
          next_st.run      = pwdata[tfvr_pkg::RUN_BIT];
          next_st.cap_en   = pwdata[tfvr_pkg::CAP_EN_BIT];
        end
        tfvr_pkg::IDX_CTRL_B:
        begin
          // Upper byte and bit 4 have no storage
          next_st.low_ien = pwdata[tfvr_pkg::LOW_IEN_BIT];
          if (HAS_ALT)
          begin
            next_st.alt_oe  = pwdata[tfvr_pkg::ALT_OE_BIT];
            next_st.alt_pol = pwdata[tfvr_pkg::ALT_POL_BIT];
          end
          // A same-cycle hardware set beats a software clear
          next_st.tf  = pwdata[tfvr_pkg::MOVF_BIT] || ovf16 || ovf_h;
          next_st.tfl = pwdata[tfvr_pkg::LOVF_BIT] || ovf_l;
          next_st.tcc = pwdata[tfvr_pkg::CCMP_BIT] || m16 || mh
                        || cap_evt;
          next_st.tcl = pwdata[tfvr_pkg::LCMP_BIT] || ml;
        end
        tfvr_pkg::IDX_CNT:
        begin
          next_st.cnt[7:0] = pwdata[7:0];
          if (!st.wmode)
            next_st.cnt[15:8] = pwdata[15:8];
        end
        tfvr_pkg::IDX_CNT_HI:
          next_st.cnt[15:8] = pwdata[7:0];
        tfvr_pkg::IDX_RLD:
        begin
          next_st.rld[7:0] = pwdata[7:0];
          if (!st.wmode)
            next_st.rld[15:8] = pwdata[15:8];
        end
        tfvr_pkg::IDX_RLD_HI:
          next_st.rld[15:8] = pwdata[7:0];
        tfvr_pkg::IDX_CMP:
        begin
          next_st.cmp[7:0] = pwdata[7:0];
          if (!st.wmode)
            next_st.cmp[15:8] = pwdata[15:8];
        end
        tfvr_pkg::IDX_CMP_HI:
          next_st.cmp[15:8] = pwdata[7:0];
        default:
          next_st.cnt = cnt_nx;
      endcase
    end

    // Alternate pin: full timer in 16-bit mode, low timer in dual mode
    src_evt = st.wmode ? (ovf_l || ml) : (ovf16 || m16);
    if (next_st.alt_oe && !st.alt_oe)
      next_st.alt_out = next_st.alt_pol;
    else if (st.alt_oe && src_evt)
      next_st.alt_out = !st.alt_out;

    // Interrupt request follows the stored flags and enables
    next_st.irq = (next_st.main_ien && (next_st.tf || next_st.tcc))
                  || (next_st.low_ien && (next_st.tfl || next_st.tcl));

    // One wait state, then answer with registered data
    if (access && !st.pready)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd_val;
    end
    else
    begin
      next_st.pready  = 1'b0;
      next_st.pslverr = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (reset)
      st <= tfvr_pkg::ST_RESET;
    else
      st <= next_st;
  end

  // Every output straight from the state register
  assign pready      = st.pready;
  assign pslverr     = st.pslverr;
  assign prdata      = st.prdata;
  assign alt_pin_out = st.alt_out;
  assign alt_pin_oe  = st.alt_oe;
  assign irq         = st.irq;

  // Checks on the behaviour above
  logic rd_done;
  assign rd_done = access && st.pready && !pwrite && hit;

  sequence quiet_s;
    !wr;
  endsequence

  sequence top16_s;
    !st.wmode && st.run && (st.cnt == tfvr_pkg::FULL16);
  endsequence

  sequence toplow_s;
    st.wmode && st.run_low && (st.cnt[7:0] == tfvr_pkg::FULL8);
  endsequence

  ctrl_reserved_a: assert property (
    rd_done && (idx == tfvr_pkg::IDX_CTRL_B)
    |-> (prdata[31:8] == 24'h000000) && !prdata[4])
    else $error("control B reserved bits read nonzero");

  low_irq_gate_a: assert property (
    !st.low_ien && !st.main_ien |-> !irq)
    else $error("interrupt raised with enables clear");

  alt_absent_a: assert property (
    !HAS_ALT |-> !alt_pin_oe && !st.alt_pol)
    else $error("alternate pin bits exist on single-pin timer");

  alt_start_a: assert property (
    !alt_pin_oe ##1 alt_pin_oe |-> alt_pin_out == st.alt_pol)
    else $error("alternate pin start level differs from polarity");

  main_ovf_a: assert property (
    top16_s and quiet_s |=> st.tf && (st.cnt == $past(st.rld)))
    else $error("16-bit overflow did not set flag and reload");

  low_ovf_a: assert property (
    toplow_s and quiet_s |=> st.tfl)
    else $error("low overflow did not set low overflow flag");

  low_cmp_a: assert property (
    $rose(st.tcl) |-> $past(wr) || (st.cnt[7:0] == st.cmp[7:0]))
    else $error("low compare flag set without low match");

  cnt_upper_a: assert property (
    rd_done && (idx == tfvr_pkg::IDX_CNT) && st.wmode
    |-> prdata[15:8] == 8'h00)
    else $error("dual mode count read shows upper byte");

  cnt_high_a: assert property (
    rd_done && (idx == tfvr_pkg::IDX_CNT_HI)
    |-> prdata == {24'h000000, $past(st.cnt[15:8])})
    else $error("count high read wrong");

  flag_sticky_a: assert property (
    st.tf and quiet_s |=> st.tf)
    else $error("main overflow flag dropped without a write");

  irq_follow_a: assert property (
    st.tcc && st.main_ien |-> irq)
    else $error("interrupt missing for enabled flag");

endmodule
`default_nettype wire

/* inc/tfvr_pkg.sv */
// Package for the timer flags, value and reload register slice.
// Assumes APB with 32-bit data; a register index times four is its byte address.
`default_nettype none
package tfvr_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int IDX_W  = 6;

  // Register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_CONFIG = 6'h00;
  localparam logic [IDX_W-1:0] IDX_CNT_HI = 6'h01;
  localparam logic [IDX_W-1:0] IDX_RLD_HI = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CMP_HI = 6'h03;
  localparam logic [IDX_W-1:0] IDX_CTRL_B = 6'h08;
  localparam logic [IDX_W-1:0] IDX_CNT    = 6'h09;
  localparam logic [IDX_W-1:0] IDX_RLD    = 6'h0a;
  localparam logic [IDX_W-1:0] IDX_CMP    = 6'h0b;

  // timer_control_b bit positions
  localparam int LOW_IEN_BIT = 7;
  localparam int ALT_OE_BIT  = 6;
  localparam int ALT_POL_BIT = 5;
  localparam int MOVF_BIT    = 3;
  localparam int LOVF_BIT    = 2;
  localparam int CCMP_BIT    = 1;
  localparam int LCMP_BIT    = 0;

  // Configuration register bit positions
  localparam int WMODE_BIT    = 8;
  localparam int MAIN_IEN_BIT = 7;
  localparam int RUN_LOW_BIT  = 4;
  localparam int RUN_BIT      = 3;
  localparam int CAP_EN_BIT   = 0;

  // Reset values and counter limits
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [15:0] FULL16     = 16'hffff;
  localparam logic [7:0]  FULL8      = 8'hff;
  localparam logic [7:0]  ZERO8      = 8'h00;

  // Whole register state of the timer slice
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] rld;
    logic [15:0] cmp;
    logic        wmode;
    logic        main_ien;
    logic        run;
    logic        run_low;
    logic        cap_en;
    logic        low_ien;
    logic        alt_oe;
    logic        alt_pol;
    logic        tf;
    logic        tfl;
    logic        tcc;
    logic        tcl;
    logic        alt_out;
    logic        irq;
    logic        cap_prev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tfvr_state_t;

  localparam tfvr_state_t ST_RESET = '0;

  // Two-stage synchroniser state
  typedef struct packed {
    logic first;
    logic second;
  } tfvr_sync_t;

endpackage
`default_nettype wire

/* logic/tfvr_sync.sv */
// Two flip-flop synchroniser for one pin level.
// Assumes the pin is asynchronous to clk; output lags the pin by two edges.
`timescale 1ns/1ps
`default_nettype none
module tfvr_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Pin in, synchronised level out
  input  wire logic d,
  output logic      q
);

  tfvr_pkg::tfvr_sync_t st;
  tfvr_pkg::tfvr_sync_t next_st;

  // First stage feeds only the second stage
  always_comb
  begin
    next_st.first  = d;
    next_st.second = st.first;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign q = st.second;

endmodule
`default_nettype wire

/* sim/tfvr_timer_tb.sv */
// Self-checking bench for the timer flags, value and reload slice.
// Assumes APB answers with pready; register byte address is four times its index.
`timescale 1ns/1ps
`default_nettype none
module tfvr_timer_tb;
  // Byte addresses of the registers used here
  localparam logic [7:0] CFG = 8'h00;
  localparam logic [7:0] CHI = 8'h04;
  localparam logic [7:0] RHI = 8'h08;
  localparam logic [7:0] CB  = 8'h20;
  localparam logic [7:0] CNT = 8'h24;
  localparam logic [7:0] RLD = 8'h28;
  localparam logic [7:0] CMP = 8'h2c;

  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        capture_pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] prdata2;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        alt_pin_out;
  logic        alt_pin_oe;
  logic        alt_pin_oe2;
  logic        irq;
  int          failures;
  int          cmp_count;
  int          cycles;

  tfvr_timer tfvr_timer_i (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .capture_pin(capture_pin), .alt_pin_out(alt_pin_out),
    .alt_pin_oe(alt_pin_oe), .irq(irq)
  );

  // Single-pin instance shares the bus; only its read data and enable are watched
  if (1)
  begin : single
    tfvr_timer #(.HAS_ALT(1'b0)) tfvr_timer_i (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(), .pslverr(), .prdata(prdata2),
      .capture_pin(capture_pin), .alt_pin_out(), .alt_pin_oe(alt_pin_oe2), .irq()
    );
  end

  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer; an edge passes first so psel is never set twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do @(posedge clk); while (pready !== 1'b1);
    rd  = prdata;
    rd2 = prdata2;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask

  task automatic t_reset();
    logic [7:0] al [5] = '{CHI, RHI, CB, CNT, RLD};
    foreach (al[i]) rdchk(al[i], 32'h0000_0000, "reset value");
    rdchk(CFG, 32'h0000_0000, "mode after reset");
    chk("irq after reset", 32'h0, {31'h0, irq});
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask

  task automatic t_ctrl();
    wr(CB, 32'hffff_ffff);
    rdchk(CB, 32'h0000_00ef, "ctrl_b all ones");
    chk("ctrl_b single pin", 32'h0000_008f, rd2);
    chk("oe single pin", 32'h0, {31'h0, alt_pin_oe2});
    chk("oe two pin", 32'h1, {31'h0, alt_pin_oe});
    chk("irq low flags", 32'h1, {31'h0, irq});
    chk("alt start high", 32'h1, {31'h0, alt_pin_out});
    wr(CB, 32'h0000_0040);
    rdchk(CB, 32'h0000_0040, "flags cleared");
    chk("alt keeps level", 32'h1, {31'h0, alt_pin_out});
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(CB, 32'h0000_0000);
    wr(CB, 32'h0000_0040);
    rdchk(CB, 32'h0000_0040, "oe again");
    chk("alt start low", 32'h0, {31'h0, alt_pin_out});
    wr(CB, 32'h0000_0005);
    rdchk(CB, 32'h0000_0005, "low flags");
    chk("irq low masked", 32'h0, {31'h0, irq});
    wr(CFG, 32'h0000_0080);
    wr(CB, 32'h0000_000a);
    rdchk(CB, 32'h0000_000a, "main flags");
    chk("irq main", 32'h1, {31'h0, irq});
    wr(CFG, 32'h0000_0000);
    rdchk(CFG, 32'h0000_0000, "main irq off");
    chk("irq main masked", 32'h0, {31'h0, irq});
    wr(CB, 32'h0000_0000);
  endtask

  // Word register and its high-byte twin, in both width modes
  task automatic t_word(input logic [7:0] full, input logic [7:0] hi);
    wr(CFG, 32'h0000_0000);
    wr(full, 32'h0000_1234);
    rdchk(full, 32'h0000_1234, "word 16-bit");
    rdchk(hi, 32'h0000_0012, "high twin");
    wr(hi, 32'h0000_ffab);
    rdchk(hi, 32'h0000_00ab, "high load");
    rdchk(full, 32'h0000_ab34, "word after high");
    wr(CFG, 32'h0000_0100);
    wr(full, 32'h0000_5678);
    rdchk(full, 32'h0000_0078, "word dual");
    rdchk(hi, 32'h0000_00ab, "high kept dual");
    wr(CFG, 32'h0000_0000);
    rdchk(full, 32'h0000_ab78, "word low only");
  endtask

  task automatic t_ovf();
    wr(CMP, 32'h0000_8000);
    wr(RLD, 32'h0000_0010);
    wr(CB, 32'h0000_0040);
    wr(CNT, 32'h0000_fffe);
    wr(CFG, 32'h0000_0008);
    wr(CFG, 32'h0000_0000);
    rdchk(CB, 32'h0000_0048, "16-bit overflow");
    chk("alt toggled", 32'h1, {31'h0, alt_pin_out});
  endtask

  // Low reload equals low compare, so overflow and match share one toggle
  task automatic t_dual();
    wr(CB, 32'h0000_0000);
    wr(CB, 32'h0000_0040);
    wr(CFG, 32'h0000_0100);
    wr(CMP, 32'h0000_0012);
    wr(RLD, 32'h0000_0012);
    wr(CNT, 32'h0000_00fe);
    wr(CFG, 32'h0000_0110);
    repeat (20) @(posedge clk);
    wr(CFG, 32'h0000_0100);
    rdchk(CB, 32'h0000_0045, "low overflow and match");
    chk("alt from low timer", 32'h1, {31'h0, alt_pin_out});
    wr(CB, 32'h0000_0085);
    rdchk(CB, 32'h0000_0085, "low flags kept");
    chk("irq low enabled", 32'h1, {31'h0, irq});
    wr(CB, 32'h0000_0000);
  endtask

  task automatic t_match();
    wr(CFG, 32'h0000_0000);
    wr(CMP, 32'h0000_0030);
    wr(CNT, 32'h0000_0020);
    wr(CFG, 32'h0000_0008);
    repeat (30) @(posedge clk);
    wr(CFG, 32'h0000_0000);
    rdchk(CB, 32'h0000_0002, "16-bit match");
    wr(CB, 32'h0000_0000);
    wr(CMP, 32'h0000_f000);
    wr(CFG, 32'h0000_0009);
    rdchk(CB, 32'h0000_0000, "no capture yet");
    capture_pin <= 1'b1;
    repeat (8) @(posedge clk);
    wr(CFG, 32'h0000_0000);
    rdchk(CB, 32'h0000_0002, "capture flag");
  endtask

  // Main sequence
  initial
  begin
    failures = 0;
    cmp_count = 0;
    cycles = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    capture_pin = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_ctrl();
    t_word(CNT, CHI);
    t_word(RLD, RHI);
    t_ovf();
    t_dual();
    t_match();
    test_done();
  end
endmodule
`default_nettype wire
